// ==== hw/accel_fifo_activity_ctrl.sv ====
`timescale 1ns/10ps
// How it works
// [RULE1] Mode 111: collect while flag high, else clear
// [RULE2] Triggered collection stops once buffer would overwrite
// [RULE3] Host keeps generator one configured and latched
// [RULE4] Buffer read loads oldest set into outputs
// [RULE5] Single and burst reads both fetch samples
// [RULE6] Burst address wraps from 2Dh to 28h
// [RULE7] Inactivity drops to 10 Hz, activity restores
// [RULE8] Nonzero threshold enables detection and high-pass
// [RULE9] Threshold count equals full scale over 128
// [RULE10] Duration count equals eight sample periods
// [RULE11] Quiet 8*dur+1 periods forces code 001 internally
// [RULE12] Above threshold ends the override at once
// [RULE13] Inactivity reaches interrupt pin only when enabled
// [RULE14] Threshold 00h turns detection off
// [RULE15] Trim words load from storage before running
// [RULE16] Chip select high picks I2C, low SPI
// [RULE17] Software setting selects three-wire SPI
// [RULE18] Storage and data-ready follow the overridden rate
// [RULE19] Mode 000 keeps the buffer empty
// [RULE20] Mode 001 stores until full then stops
// [RULE21] Buffer holds 32 XYZ sample sets
module accel_fifo_activity_ctrl #(
    parameter int unsigned SLOW_PERIOD = accel_pkg::SLOW_PERIOD_CYC
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire accel_pkg::axis_t                       sample_x,
    input  wire accel_pkg::axis_t                       sample_y,
    input  wire accel_pkg::axis_t                       sample_z,
    output logic                                        data_ready,
    input  wire logic [2:0]                             buffer_mode_field,
    input  wire logic                                   gen1_event_flag,
    input  wire logic [2:0]                             output_sample_rate,
    input  wire logic [7:0]                             activity_threshold_reg,
    input  wire logic [7:0]                             activity_duration_reg,
    input  wire logic                                   inactivity_irq_enable,
    output logic                                        accel_irq_pin,
    output logic                                        inactive,
    output logic                                        hpf_enable,
    output logic [2:0]                                  effective_rate,
    output logic [accel_pkg::PTR_W:0]                   fifo_level,
    output logic                                        fifo_empty,
    output logic                                        fifo_overrun,
    output logic [2:0]                                  trim_rd_addr,
    input  wire logic [15:0]                            trim_rd_data,
    output logic [accel_pkg::TRIM_WORDS-1:0][15:0]      trim_words,
    output logic                                        trim_done,
    input  wire logic                                   accel_chip_select,
    input  wire logic                                   three_wire_sel,
    output logic                                        spi_enable,
    output logic                                        i2c_enable,
    output logic                                        spi_three_wire,
    input  wire logic                                   rd_req_valid,
    output logic                                        rd_req_ready,
    input  wire logic                                   rd_req_first,
    input  wire logic [6:0]                             rd_req_addr,
    output logic                                        rd_data_valid,
    input  wire logic                                   rd_data_ready,
    output logic [7:0]                                  rd_data
);
    import accel_pkg::*;

    typedef enum logic [1:0] {TRIM_ADDR, TRIM_DATA, RUN} boot_t;

    typedef struct packed {
        boot_t                            boot;
        logic [2:0]                       trim_idx;
        logic [TRIM_WORDS-1:0][15:0]      trim;
        logic                             cs_meta;
        logic                             cs_sync;
        logic [TICK_W-1:0]                tick_cnt;
        logic                             tick;
        sample_t                          prev;
        logic [QUIET_W-1:0]               quiet;
        logic                             inact;
        logic [PTR_W:0]                   wr_ptr;
        logic [PTR_W:0]                   rd_ptr;
        logic                             ovr;
        sample_t                          out;
        logic [6:0]                       addr;
    } state_t;

    state_t            s_q;
    state_t            s_d;
    sample_t           mem [DEPTH];
    sample_t           cur;
    sample_t           head_word;
    logic [TICK_W-1:0] period_tab [8];
    logic [TICK_W-1:0] period;
    logic              det_on;
    logic              above;
    logic              collecting;
    logic              full;
    logic              push;
    logic              accept;
    logic [6:0]        addr_cur;
    logic              pop;
    logic [QUIET_W-1:0] quiet_need;

    byte_stream_if rd_fill ();
    byte_stream_if rd_drain ();

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic over_ths(axis_t a, axis_t b, logic [7:0] ths);
        logic signed [16:0] d;
        logic        [16:0] mag;
        d   = $signed({a[15], a}) - $signed({b[15], b});
        mag = d[16] ? 17'(-d) : 17'(d);
        return mag > {1'b0, ths, 8'h00};
    endfunction

    function automatic logic [7:0] pick_byte(sample_t s, logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            3'h0: b = s.x[7:0];
            3'h1: b = s.x[15:8];
            3'h2: b = s.y[7:0];
            3'h3: b = s.y[15:8];
            3'h4: b = s.z[7:0];
            3'h5: b = s.z[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    for (genvar g = 0; g < 8; g++) begin : g_period
        assign period_tab[g] = TICK_W'(SLOW_PERIOD / RATE_DIV[g]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Combinational view

    assign cur        = '{x: sample_x, y: sample_y, z: sample_z};
    assign det_on     = (activity_threshold_reg != 8'h00);                    // [RULE8] [RULE14]
    assign above      = over_ths(cur.x, s_q.prev.x, activity_threshold_reg) | // [RULE9]
                        over_ths(cur.y, s_q.prev.y, activity_threshold_reg) |
                        over_ths(cur.z, s_q.prev.z, activity_threshold_reg);
    assign quiet_need = QUIET_W'({1'b0, activity_duration_reg, 3'b000}) + 12'h001; // [RULE10]
    assign effective_rate = s_q.inact ? RATE_10HZ : output_sample_rate;       // [RULE11] [RULE7]
    assign period     = period_tab[effective_rate];                           // [RULE18]

    assign collecting = (buffer_mode_field == MODE_FIFO) |                    // [RULE20]
                        ((buffer_mode_field == MODE_TRIG_FIFO) & gen1_event_flag); // [RULE1] [RULE3]
    assign full       = (s_q.wr_ptr - s_q.rd_ptr) == (PTR_W+1)'(DEPTH);       // [RULE21]
    assign push       = s_q.tick & collecting & ~full;                        // [RULE2]
    assign head_word  = mem[s_q.rd_ptr[PTR_W-1:0]];

    assign rd_req_ready = rd_fill.ready & (s_q.boot == RUN);
    assign accept     = rd_req_valid & rd_req_ready;                          // [RULE5]
    assign addr_cur   = rd_req_first ? rd_req_addr : s_q.addr;
    assign pop        = accept & (addr_cur == ADDR_X_LO) & collecting & ~fifo_empty; // [RULE4]

    always_comb begin
        rd_fill.valid = accept;
        rd_fill.data  = 8'h00;
        if (addr_cur >= ADDR_X_LO && addr_cur <= ADDR_Z_HI) begin
            rd_fill.data = pick_byte(pop ? head_word : s_q.out, 3'(addr_cur - ADDR_X_LO));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;

        s_d.cs_meta = accel_chip_select;
        s_d.cs_sync = s_q.cs_meta;

        unique case (s_q.boot)
            TRIM_ADDR: s_d.boot = TRIM_DATA;
            TRIM_DATA: begin
                s_d.trim[s_q.trim_idx] = trim_rd_data;                        // [RULE15]
                s_d.trim_idx           = 3'(s_q.trim_idx + 3'h1);
                s_d.boot               = (s_q.trim_idx == TRIM_LAST) ? RUN : TRIM_ADDR;
            end
            RUN: ;
        endcase

        // Sample clock follows the effective rate
        if (s_q.boot != RUN || effective_rate == RATE_OFF || effective_rate == RATE_TOP) begin
            s_d.tick_cnt = '0;
        end else if (s_q.tick_cnt >= TICK_W'(period - 24'h1)) begin
            s_d.tick_cnt = '0;
            s_d.tick     = 1'b1;                                              // [RULE18]
        end else begin
            s_d.tick_cnt = TICK_W'(s_q.tick_cnt + 24'h1);
        end

        // Activity and inactivity detection on each sample
        if (!det_on) begin
            s_d.quiet = '0;                                                   // [RULE14]
            s_d.inact = 1'b0;
        end else if (s_q.tick) begin
            if (above) begin
                s_d.quiet = '0;                                               // [RULE12]
                s_d.inact = 1'b0;
            end else begin
                if (s_q.quiet != {QUIET_W{1'b1}}) begin
                    s_d.quiet = QUIET_W'(s_q.quiet + 12'h001);
                end
                if (QUIET_W'(s_q.quiet + 12'h001) >= quiet_need) begin
                    s_d.inact = 1'b1;                                         // [RULE11] [RULE7]
                end
            end
        end
        if (s_q.tick) begin
            s_d.prev = cur;
        end

        // Buffer pointers
        if (!collecting) begin
            s_d.wr_ptr = '0;                                                  // [RULE19] [RULE1]
            s_d.rd_ptr = '0;
            s_d.ovr    = 1'b0;
            if (s_q.tick) begin
                s_d.out = cur;
            end
        end else begin
            if (push) begin
                s_d.wr_ptr = (PTR_W+1)'(s_q.wr_ptr + 6'h01);
            end
            if (s_q.tick && full) begin
                s_d.ovr = 1'b1;                                               // [RULE2] [RULE20]
            end
            if (pop) begin
                s_d.rd_ptr = (PTR_W+1)'(s_q.rd_ptr + 6'h01);
                s_d.out    = head_word;                                       // [RULE4]
            end
        end

        if (accept) begin
            s_d.addr = (addr_cur == ADDR_Z_HI) ? ADDR_X_LO : 7'(addr_cur + 7'h01); // [RULE6]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q      <= '0;
            s_q.boot <= TRIM_ADDR;
            s_q.addr <= ADDR_X_LO;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_q.wr_ptr[PTR_W-1:0]] <= cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path buffer and outputs

    two_entry_buf u_rd_buf (
        .clk   (clk),
        .rst   (rst),
        .fill  (rd_fill),
        .drain (rd_drain)
    );

    assign rd_drain.ready = rd_data_ready;
    assign rd_data_valid  = rd_drain.valid;
    assign rd_data        = rd_drain.data;

    assign data_ready     = s_q.tick;
    assign inactive       = s_q.inact;
    assign hpf_enable     = det_on;                                           // [RULE8]
    assign accel_irq_pin  = s_q.inact & inactivity_irq_enable;                // [RULE13]
    assign fifo_level     = s_q.wr_ptr - s_q.rd_ptr;
    assign fifo_empty     = (s_q.wr_ptr == s_q.rd_ptr);
    assign fifo_overrun   = s_q.ovr;
    assign trim_rd_addr   = s_q.trim_idx;
    assign trim_words     = s_q.trim;
    assign trim_done      = (s_q.boot == RUN);
    assign i2c_enable     = s_q.cs_sync;                                      // [RULE16]
    assign spi_enable     = ~s_q.cs_sync;
    assign spi_three_wire = ~s_q.cs_sync & three_wire_sel;                    // [RULE17]

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence quiet_sample;
        s_q.tick && det_on && !above;
    endsequence

    sequence loud_sample;
        s_q.tick && det_on && above;
    endsequence

    bypass_stays_empty_a: assert property (                                  // [RULE19]
        buffer_mode_field == MODE_BYPASS |=> fifo_empty && !fifo_overrun)
        else $error("buffer not empty in bypass");

    trigger_low_clear_a: assert property (                                   // [RULE1]
        buffer_mode_field == MODE_TRIG_FIFO && !gen1_event_flag |=> fifo_level == '0)
        else $error("gated buffer kept data without trigger");

    full_stops_a: assert property (                                          // [RULE2]
        collecting && full && s_q.tick |=> $stable(s_q.wr_ptr) && fifo_overrun)
        else $error("full buffer kept storing");

    burst_wrap_a: assert property (                                          // [RULE6]
        accept && addr_cur == ADDR_Z_HI |=> s_q.addr == ADDR_X_LO)
        else $error("burst address did not wrap");

    pop_loads_a: assert property (                                           // [RULE4]
        pop |=> s_q.out == $past(head_word) && fifo_level == $past(fifo_level) - 6'h01
                + {5'h00, $past(push)})
        else $error("buffer read did not load oldest set");

    override_rate_a: assert property (                                       // [RULE11]
        quiet_sample ##0 (QUIET_W'(s_q.quiet + 12'h001) >= quiet_need)
        |=> inactive ##0 effective_rate == RATE_10HZ)
        else $error("inactivity override missing");

    wake_at_once_a: assert property (                                        // [RULE12]
        loud_sample |=> !inactive && effective_rate == $past(output_sample_rate))
        else $error("activity did not restore rate");

    off_clears_a: assert property (                                          // [RULE14]
        !det_on |=> !inactive && s_q.quiet == '0)
        else $error("detection active with zero threshold");

    irq_gate_a: assert property (                                            // [RULE13]
        inactive && !inactivity_irq_enable |-> !accel_irq_pin)
        else $error("inactivity reached pin while disabled");

    trim_first_a: assert property (                                          // [RULE15]
        $rose(trim_done) |-> $past(s_q.trim_idx) == TRIM_LAST && !$past(rd_req_ready))
        else $error("run started before trim load");

    cs_select_a: assert property (                                           // [RULE16]
        accel_chip_select [*3] |-> i2c_enable && !spi_enable)
        else $error("chip select high did not pick I2C");

endmodule // accel_fifo_activity_ctrl

// ==== hw/accel_pkg.sv ====
package accel_pkg;

    // Clock and sample-rate timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int SLOW_RATE_HZ    = 10;
    localparam int SLOW_PERIOD_CYC = CLK_HZ / SLOW_RATE_HZ;
    // Divisor of the 10 Hz period for each rate code (0 and 7 are off)
    localparam int RATE_DIV [8]    = '{1, 1, 5, 10, 20, 40, 80, 1};
    localparam int TICK_W          = 24;

    // Rate codes
    localparam logic [2:0] RATE_OFF  = 3'h0;
    localparam logic [2:0] RATE_10HZ = 3'h1;
    localparam logic [2:0] RATE_TOP  = 3'h7;

    // Buffer mode codes
    localparam logic [2:0] MODE_BYPASS    = 3'h0;
    localparam logic [2:0] MODE_FIFO      = 3'h1;
    localparam logic [2:0] MODE_TRIG_FIFO = 3'h7;

    // Buffer geometry
    localparam int DEPTH = 32;
    localparam int PTR_W = 5;

    // Output register window for burst reads
    localparam logic [6:0] ADDR_X_LO = 7'h28;
    localparam logic [6:0] ADDR_Z_HI = 7'h2d;

    // One threshold count is full scale / 128, i.e. 2^15 / 2^7 raw counts
    localparam int THS_SHIFT = 8;
    // One duration count is eight sample periods
    localparam int DUR_SHIFT = 3;
    localparam int QUIET_W   = 12;

    // Factory trim words: sensitivity x,y,z then offset x,y,z
    localparam int         TRIM_WORDS = 6;
    localparam logic [2:0] TRIM_LAST  = 3'h5;

    typedef logic [15:0] axis_t;

    typedef struct packed {
        axis_t x;
        axis_t y;
        axis_t z;
    } sample_t;

endpackage

// ==== hw/byte_stream_if.sv ====
`timescale 1ns/10ps
interface byte_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hw/two_entry_buf.sv ====
`timescale 1ns/10ps
module two_entry_buf (
    input  wire logic   clk,
    input  wire logic   rst,
    byte_stream_if.snk  fill,
    byte_stream_if.src  drain
);

    typedef struct packed {
        logic [1:0][7:0] slot;
        logic            head;
        logic [1:0]      count;
    } buf_state_t;

    buf_state_t s_q;
    buf_state_t s_d;
    logic       push;
    logic       pop;

    assign fill.ready  = (s_q.count != 2'h2);
    assign drain.valid = (s_q.count != 2'h0);
    assign drain.data  = s_q.slot[s_q.head];
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.slot[s_q.head ^ s_q.count[0]] = fill.data;
        end
        if (pop) begin
            s_d.head = ~s_q.head;
        end
        s_d.count = 2'(s_q.count + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // two_entry_buf

// ==== test/host_model.sv ====
`timescale 1ns/10ps
module host_model (
    input  wire logic clk,
    input  wire logic rst,
    output logic      rd_data_ready
);
    int seed = 63;
    int t    = 0;

    initial rd_data_ready = 1'b0;

    // Random short stalls plus a six-cycle stall every 32 cycles fill the byte buffer
    always @(posedge clk) begin
        #1;
        t++;
        rd_data_ready = !rst && (t % 32 > 5) && (($random(seed) & 3) != 0);
    end
endmodule // host_model

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
    import accel_pkg::*;
    localparam int SP = 80;

    logic                         clk = 1'b0;
    logic                         rst = 1'b1;
    axis_t                        sample_x = '0, sample_y = '0, sample_z = '0, qv = '0;
    logic [2:0]                   mode = 3'h0, rate = 3'h6, effective_rate, trim_rd_addr;
    logic                         flag = 1'b0, irq_en = 1'b0, cs = 1'b1, tw = 1'b0, quiet = 1'b0;
    logic [7:0]                   ths = 8'h00, dur = 8'h00, rd_data;
    logic [15:0]                  trim_rd_data = 16'h0000;
    logic                         rq_v = 1'b0, rq_f = 1'b0;
    logic [6:0]                   rq_a = 7'h00, na = 7'h28;
    logic                         data_ready, accel_irq_pin, inactive, hpf_enable, fifo_empty;
    logic                         fifo_overrun, trim_done, spi_enable, i2c_enable, spi_three_wire;
    logic                         rd_req_ready, rd_data_valid, rd_data_ready;
    logic [PTR_W:0]               fifo_level;
    logic [TRIM_WORDS-1:0][15:0]  trim_words;
    int                           bad_count = 0, checks_done = 0, seed = 63, n;
    sample_t                      mq[$], cur;
    logic [7:0]                   eq[$];

    initial forever #5 clk = ~clk;

    accel_fifo_activity_ctrl #(.SLOW_PERIOD(SP)) dut (
        .clk(clk), .rst(rst), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
        .data_ready(data_ready), .buffer_mode_field(mode), .gen1_event_flag(flag),
        .output_sample_rate(rate), .activity_threshold_reg(ths), .activity_duration_reg(dur),
        .inactivity_irq_enable(irq_en), .accel_irq_pin(accel_irq_pin), .inactive(inactive),
        .hpf_enable(hpf_enable), .effective_rate(effective_rate), .fifo_level(fifo_level),
        .fifo_empty(fifo_empty), .fifo_overrun(fifo_overrun), .trim_rd_addr(trim_rd_addr),
        .trim_rd_data(trim_rd_data), .trim_words(trim_words), .trim_done(trim_done),
        .accel_chip_select(cs), .three_wire_sel(tw), .spi_enable(spi_enable),
        .i2c_enable(i2c_enable), .spi_three_wire(spi_three_wire), .rd_req_valid(rq_v),
        .rd_req_ready(rd_req_ready), .rd_req_first(rq_f), .rd_req_addr(rq_a),
        .rd_data_valid(rd_data_valid), .rd_data_ready(rd_data_ready), .rd_data(rd_data));

    host_model host (.clk(clk), .rst(rst), .rd_data_ready(rd_data_ready));

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) trim_rd_data <= 16'ha500 | {13'h0000, trim_rd_addr};

    always @(posedge clk) begin
        #1;
        sample_x = quiet ? qv : 16'($random(seed));
        sample_y = quiet ? qv : 16'($random(seed));
        sample_z = quiet ? qv : 16'($random(seed));
    end

    // Reference buffer: what a collecting buffer must hold, and every byte read out
    always @(posedge clk) begin
        if (!(mode == MODE_FIFO || (mode == MODE_TRIG_FIFO && flag)))
            mq.delete();
        else if (data_ready === 1'b1 && mq.size() < DEPTH)
            mq.push_back({sample_x, sample_y, sample_z});
        if (rd_data_valid === 1'b1 && rd_data_ready === 1'b1)
            chk(16'(rd_data), 16'(eq.pop_front()));
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Always lets one edge pass, so the flag is judged by its value at an edge
    task automatic seek(ref logic s, input logic v, input int lim);
        @(posedge clk);
        for (int k = 0; k < lim && s !== v; k++) @(posedge clk);
    endtask

    function automatic logic [7:0] pick(sample_t s, logic [6:0] a);
        case (a)
            7'h28:   return s.x[7:0];
            7'h29:   return s.x[15:8];
            7'h2a:   return s.y[7:0];
            7'h2b:   return s.y[15:8];
            7'h2c:   return s.z[7:0];
            7'h2d:   return s.z[15:8];
            default: return 8'h00;
        endcase
    endfunction

    // Request is held from just after an edge until the edge that takes it
    task automatic rd(logic f, logic [6:0] a);
        logic ok;
        if (f) na = a;
        rq_v = 1'b1;
        rq_f = f;
        rq_a = a;
        do begin
            #1 ok = rd_req_ready;
            @(posedge clk);
        end while (ok !== 1'b1);
        if (na == ADDR_X_LO && mq.size() > 0) cur = mq.pop_front();
        eq.push_back(pick(cur, na));
        na = (na == ADDR_Z_HI) ? ADDR_X_LO : na + 7'h01;
        #1;
    endtask

    task automatic results();
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        seek(trim_done, 1'b1, 100);
        #1;
        for (int i = 0; i < TRIM_WORDS; i++) chk(trim_words[i], 16'ha500 | 16'(i));
        chk(16'(i2c_enable), 16'h0001);
        chk(16'(spi_enable), 16'h0000);
        cs = 1'b0;
        tw = 1'b1;
        cyc(4);
        chk(16'({spi_enable, i2c_enable}), 16'h0002);
        chk(16'(spi_three_wire), 16'h0001);
        tw = 1'b0;
        cyc(1);
        chk(16'(spi_three_wire), 16'h0000);
        cs = 1'b1;
        cyc(20);
        chk(16'({fifo_level, fifo_empty}), 16'h0001);
        mode = MODE_FIFO;
        cyc(60);
        chk(16'({fifo_level, fifo_overrun}), 16'h0041);
        rate = RATE_OFF;
        cyc(2);
        rd(1'b1, ADDR_X_LO);
        for (int i = 0; i < 11; i++) rd(1'b0, 7'h00);
        rd(1'b1, 7'h2a);
        rd(1'b1, 7'h30);
        rd(1'b1, ADDR_X_LO);
        rq_v = 1'b0;
        cyc(30);
        chk(16'(fifo_level), 16'd29);
        chk(16'(eq.size()), 16'h0000);
        mode = MODE_TRIG_FIFO;
        rate = 3'h6;
        cyc(20);
        chk(16'(fifo_level), 16'h0000);
        flag = 1'b1;
        cyc(10);
        chk(16'(fifo_level != 0), 16'h0001);
        cyc(50);
        chk(16'({fifo_level, fifo_overrun}), 16'h0041);
        flag = 1'b0;
        cyc(3);
        chk(16'({fifo_level, fifo_empty}), 16'h0001);
        mode = 3'h3;
        flag = 1'b1;
        cyc(5);
        chk(16'({fifo_level, fifo_empty}), 16'h0001);
        flag = 1'b0;
        mode = MODE_BYPASS;
        quiet = 1'b1;
        qv = 16'h0100;
        rate = 3'h5;
        dur = 8'h02;
        cyc(10);
        ths = 8'h01;
        n = 0;
        for (int k = 0; k < 2000; k++) begin
            @(posedge clk);
            if (inactive === 1'b1) break;
            if (data_ready === 1'b1) n++;
        end
        #1;
        chk(16'(n), 16'd17);
        chk(16'(hpf_enable), 16'h0001);
        chk(16'(effective_rate), 16'(RATE_10HZ));
        chk(16'(accel_irq_pin), 16'h0000);
        irq_en = 1'b1;
        cyc(1);
        chk(16'(accel_irq_pin), 16'h0001);
        seek(data_ready, 1'b1, 300);
        @(posedge clk);
        n = 1;
        while (data_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n), 16'(SP));
        #1 qv = 16'h4100;
        seek(inactive, 1'b0, 300);
        #1;
        chk(16'({inactive, effective_rate}), 16'(rate));
        ths = 8'h00;
        cyc(2);
        chk(16'({hpf_enable, accel_irq_pin}), 16'h0000);
        results();
    end
endmodule // tb
